/* File: verilog/apbmc_pkg.sv */
package apbmc_pkg;
  // transfer-controller clock is the system clock halved
  localparam int SYS_CLK_HZ = 20000000;
  localparam int XFER_DIV = 2;
  localparam int TIMER_CLK_HZ = 1190000;
  // 8-bit channels 0..3, 16-bit channels 5..7, channel 4 is cascade
  localparam int NUM_CHAN = 8;
  localparam int CASCADE_CHAN = 4;
  localparam int LOW_AW = 10;
  localparam int MID_AW = 7;
  localparam int UP_AW = 7;
  localparam int NUM_IRQ = 16;
  localparam int TIMER_IRQ = 0;
  localparam int CASCADE_IRQ = 2;
  // address decode ranges on low address bits 9..5
  localparam logic [4:0] SEL_BYTE_CTRL = 5'h00;
  localparam logic [4:0] SEL_INT_LO = 5'h01;
  localparam logic [4:0] SEL_TIMER = 5'h02;
  localparam logic [4:0] SEL_PAGE = 5'h04;
  localparam logic [4:0] SEL_INT_HI = 5'h05;
  localparam logic [4:0] SEL_WORD_CTRL = 5'h06;
  // counter two gate port: range 5'h03 with bit 4 low and bit 0 high
  localparam logic [4:0] SEL_PORT_GATE = 5'h03;
  localparam int PORT_GATE_CLR_BIT = 4;
  localparam int PORT_GATE_SET_BIT = 0;
  localparam int SEL_LSB = 5;
  // timer reload defaults, arbitrary plain values
  localparam logic [15:0] REFRESH_RELOAD = 16'h0012;
  localparam logic [15:0] TICK_RELOAD = 16'hffff;
  localparam logic [15:0] TONE_RELOAD = 16'h0533;
  localparam logic [23:0] REFRESH_ADDR = 24'h000000;
  localparam logic [23:0] BASE_ADDR_RESET = 24'h000000;

  typedef enum logic [2:0] {
    APBMC_IDLE = 3'b000,
    APBMC_HOLD = 3'b001,
    APBMC_ADDR = 3'b010,
    APBMC_WAIT = 3'b011,
    APBMC_STRB = 3'b100,
    APBMC_DONE = 3'b101
  } apbmc_state_t;
endpackage : apbmc_pkg

/* File: verilog/apbmc_sync.sv */
`timescale 1ns/1ns
module apbmc_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } apbmc_sync_t;
  apbmc_sync_t state_ff;
  apbmc_sync_t nxt_state;

  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.meta = asyncIn;
    nxt_state.held = state_ff.meta;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign syncOut = state_ff.held;
endmodule : apbmc_sync

/* File: verilog/apbmc_ctrl.sv */
`timescale 1ns/1ns
module apbmc_ctrl
  import apbmc_pkg::*;
#(
  parameter int XFER_COUNT = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic resetIn,
  input wire logic [NUM_CHAN-1:0] transferRequestLines,
  input wire logic [NUM_IRQ-1:0] interruptRequestLines,
  input wire logic interruptAckIn,
  input wire logic busHoldGrant,
  input wire logic masterIn_b,
  input wire logic channelReadyIn,
  input wire logic timerClockIn,
  input wire logic [LOW_AW-1:0] lowAddrIn,
  input wire logic ioWriteStrobeIn_b,
  input wire logic memWriteStrobeIn_b,
  input wire logic refreshIn_b,
  input wire logic [7:0] dataIn,
  input wire logic ackActiveHigh,
  output logic [LOW_AW-1:0] lowPeripheralAddress,
  output logic lowAddrOe_b,
  output logic [MID_AW-1:0] midPeripheralAddress,
  output logic midAddrOe_b,
  output logic [UP_AW-1:0] upperHostAddress,
  output logic upperAddrOe_b,
  output logic ioWriteStrobe_b,
  output logic ioReadStrobe_b,
  output logic memWriteStrobe_b,
  output logic memReadStrobe_b,
  output logic strobeOe_b,
  output logic [7:0] peripheralDataBus,
  output logic dataOe_b,
  output logic cpuInterruptOut,
  output logic [NUM_CHAN-1:0] transferAckLines,
  output logic busHoldRequest,
  output logic byteCtrlAddrEnable_b,
  output logic wordCtrlAddrEnable_b,
  output logic terminalCount,
  output logic counterTwoOutput,
  output logic refreshOut,
  output logic refreshOe_b,
  output logic [6:0] chipSelects
);
  initial begin
    if (XFER_COUNT < 1 || XFER_COUNT > 65535) $error("bad transfer count");
  end

  typedef struct packed {
    logic xferEn;
    apbmc_state_t state;
    logic [2:0] chan;
    logic refreshCyc;
    logic arbEnable;
    logic [15:0] remain;
    logic [23:0] addr;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] cnt0;
    logic tmrClkQ;
    logic refreshDue;
    logic counter_two_output;
    logic out0;
    logic gate2;
    logic ackSeen;
    logic [LOW_AW-1:0] lowA;
    logic lowOe_b;
    logic [MID_AW-1:0] midA;
    logic midOe_b;
    logic [UP_AW-1:0] upA;
    logic upOe_b;
    logic iow_b;
    logic ior_b;
    logic memw_b;
    logic memr_b;
    logic strbOe_b;
    logic [7:0] data;
    logic dOe_b;
    logic cpu_interrupt_out;
    logic [NUM_CHAN-1:0] ack;
    logic hrq;
    logic byte_ctrl_addr_enable_b;
    logic word_ctrl_addr_enable_b;
    logic tc;
    logic refOut;
    logic refOe_b;
    logic [6:0] cs;
  } apbmc_ctrl_t;

  apbmc_ctrl_t state_ff;
  apbmc_ctrl_t nxt_state;
  logic [NUM_CHAN-1:0] reqSync;
  logic [NUM_IRQ-1:0] irqSync;
  logic [NUM_IRQ-1:0] irqAll;
  logic tmrEdge;
  logic xferTick;
  logic syncRst_b;

  apbmc_sync #(.WIDTH(NUM_CHAN)) uReqSync (
    .clock(clock),
    .rst_b(syncRst_b),
    .asyncIn(transferRequestLines),
    .syncOut(reqSync)
  );
  apbmc_sync #(.WIDTH(NUM_IRQ)) uIrqSync (
    .clock(clock),
    .rst_b(syncRst_b),
    .asyncIn(interruptRequestLines),
    .syncOut(irqSync)
  );

  function automatic logic [2:0] pickChan(input logic [NUM_CHAN-1:0] req);
    logic [2:0] c;
    c = 3'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (req[i] && i != CASCADE_CHAN) c = 3'(i);
    end
    return c;
  endfunction : pickChan

  function automatic logic [15:0] countDown(input logic [15:0] v, input logic [15:0] rl);
    return (v == 16'h0000) ? rl : v - 16'h0001;
  endfunction : countDown

  // lowest pending request index, used as the vector
  function automatic logic [7:0] pickIrq(input logic [NUM_IRQ-1:0] req);
    logic [7:0] v;
    v = 8'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) v = 8'(i);
    end
    return v;
  endfunction : pickIrq

  assign xferTick = state_ff.xferEn;
  // stale synchroniser contents would start a stray transfer after reset
  assign syncRst_b = rst_b & ~resetIn;
  assign tmrEdge = timerClockIn & ~state_ff.tmrClkQ;
  always_comb begin
    irqAll = irqSync;
    irqAll[TIMER_IRQ] = state_ff.out0;
    irqAll[CASCADE_IRQ] = 1'b0;
  end

  always_comb begin
    logic [NUM_CHAN-1:0] req;
    logic grantOk;
    logic [4:0] sel;
    logic refreshSet;
    logic [23:0] outA;
    req = '0;
    grantOk = 1'b0;
    sel = '0;
    refreshSet = 1'b0;
    outA = '0;
    nxt_state = state_ff;
    nxt_state.xferEn = ~state_ff.xferEn;
    nxt_state.tmrClkQ = timerClockIn;
    nxt_state.tc = 1'b0;
    req = reqSync;
    req[CASCADE_CHAN] = 1'b0;
    grantOk = busHoldGrant && masterIn_b;
    // refresh selects the mapper's refresh entry without losing the transfer address
    outA = state_ff.refreshCyc ? REFRESH_ADDR : state_ff.addr;
    nxt_state.upOe_b = !grantOk;
    nxt_state.upA = outA[LOW_AW+MID_AW+UP_AW-1:LOW_AW+MID_AW];
    if (tmrEdge) begin
      nxt_state.cnt0 = countDown(state_ff.cnt0, TICK_RELOAD);
      nxt_state.cnt1 = countDown(state_ff.cnt1, REFRESH_RELOAD);
      if (state_ff.cnt0 == 16'h0000) nxt_state.out0 = ~state_ff.out0;
      if (state_ff.cnt1 == 16'h0000) refreshSet = 1'b1;
      if (state_ff.gate2) begin
        nxt_state.cnt2 = countDown(state_ff.cnt2, TONE_RELOAD);
        if (state_ff.cnt2 == 16'h0000) nxt_state.counter_two_output = ~state_ff.counter_two_output;
      end
    end
    if (!refreshIn_b && state_ff.refOe_b) refreshSet = 1'b1;
    if (refreshSet) nxt_state.refreshDue = 1'b1;
    nxt_state.cpu_interrupt_out = |irqAll;
    if (!interruptAckIn) begin
      nxt_state.ackSeen = 1'b1;
      nxt_state.arbEnable = 1'b0;
      nxt_state.data = pickIrq(irqAll);
      nxt_state.dOe_b = 1'b0;
    end else begin
      nxt_state.dOe_b = 1'b1;
    end
    // a new acknowledge in the same cycle keeps the arbiter off
    if (state_ff.ackSeen && interruptAckIn && !memWriteStrobeIn_b
        && state_ff.strbOe_b) begin
      nxt_state.arbEnable = 1'b1;
      nxt_state.ackSeen = 1'b0;
    end
    sel = lowAddrIn[LOW_AW-1:SEL_LSB];
    nxt_state.cs = '0;
    if (!(busHoldGrant && masterIn_b)) begin
      nxt_state.cs[0] = (sel == SEL_BYTE_CTRL);
      nxt_state.cs[1] = (sel == SEL_INT_LO);
      nxt_state.cs[2] = (sel == SEL_TIMER);
      nxt_state.cs[3] = (sel == SEL_PAGE);
      nxt_state.cs[4] = (sel == SEL_INT_HI);
      nxt_state.cs[5] = (sel == SEL_WORD_CTRL);
      nxt_state.cs[6] = (sel == SEL_PORT_GATE) && !lowAddrIn[PORT_GATE_CLR_BIT]
        && lowAddrIn[PORT_GATE_SET_BIT];
      if (nxt_state.cs[6] && !ioWriteStrobeIn_b) nxt_state.gate2 = dataIn[0];
    end
    if (state_ff.state == APBMC_IDLE) nxt_state.ack = ackActiveHigh ? '0 : '1;
    if (!masterIn_b) begin
      nxt_state.state = APBMC_IDLE;
      nxt_state.hrq = 1'b0;
    end else if (xferTick) begin
      unique case (state_ff.state)
        APBMC_IDLE: begin
          if (state_ff.arbEnable && (state_ff.refreshDue || (|req))) begin
            nxt_state.hrq = 1'b1;
            nxt_state.refreshCyc = state_ff.refreshDue;
            nxt_state.chan = pickChan(req);
            nxt_state.state = APBMC_HOLD;
          end
        end
        APBMC_HOLD: begin
          if (grantOk) begin
            nxt_state.state = APBMC_ADDR;
            if (state_ff.refreshCyc) begin
              nxt_state.refOut = 1'b0;
              nxt_state.refOe_b = 1'b0;
            end
          end
        end
        APBMC_ADDR: begin
          nxt_state.lowA = outA[LOW_AW-1:0];
          nxt_state.midA = outA[LOW_AW+MID_AW-1:LOW_AW];
          nxt_state.lowOe_b = 1'b0;
          nxt_state.midOe_b = 1'b0;
          nxt_state.strbOe_b = 1'b0;
          if (!state_ff.refreshCyc) begin
            nxt_state.ack[state_ff.chan] = ~ackActiveHigh ^ 1'b1;
            nxt_state.byte_ctrl_addr_enable_b = state_ff.chan[2];
            nxt_state.word_ctrl_addr_enable_b = ~state_ff.chan[2];
            nxt_state.ior_b = 1'b0;
          end
          nxt_state.state = APBMC_WAIT;
        end
        APBMC_WAIT: begin
          nxt_state.memw_b = state_ff.refreshCyc;
          nxt_state.memr_b = 1'b0;
          nxt_state.state = APBMC_STRB;
        end
        APBMC_STRB: begin
          if (channelReadyIn) begin
            nxt_state.state = APBMC_DONE;
          end
        end
        APBMC_DONE: begin
          nxt_state.iow_b = 1'b1;
          nxt_state.ior_b = 1'b1;
          nxt_state.memw_b = 1'b1;
          nxt_state.memr_b = 1'b1;
          nxt_state.strbOe_b = 1'b1;
          nxt_state.lowOe_b = 1'b1;
          nxt_state.midOe_b = 1'b1;
          nxt_state.byte_ctrl_addr_enable_b = 1'b1;
          nxt_state.word_ctrl_addr_enable_b = 1'b1;
          nxt_state.ack = ackActiveHigh ? '0 : '1;
          nxt_state.refOut = 1'b1;
          nxt_state.refOe_b = 1'b1;
          nxt_state.hrq = 1'b0;
          if (state_ff.refreshCyc) begin
            nxt_state.refreshDue = refreshSet;
          end else begin
            nxt_state.addr = state_ff.addr + 24'h000001;
            if (state_ff.remain == 16'h0000) begin
              nxt_state.tc = 1'b1;
              nxt_state.remain = 16'(XFER_COUNT - 1);
            end else begin
              nxt_state.remain = state_ff.remain - 16'h0001;
            end
          end
          nxt_state.state = APBMC_IDLE;
        end
        default: nxt_state.state = APBMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || resetIn) begin
      state_ff <= '0;
      state_ff.arbEnable <= 1'b1;
      state_ff.remain <= 16'(XFER_COUNT - 1);
      state_ff.addr <= BASE_ADDR_RESET;
      state_ff.lowOe_b <= 1'b1;
      state_ff.midOe_b <= 1'b1;
      state_ff.upOe_b <= 1'b1;
      state_ff.iow_b <= 1'b1;
      state_ff.ior_b <= 1'b1;
      state_ff.memw_b <= 1'b1;
      state_ff.memr_b <= 1'b1;
      state_ff.strbOe_b <= 1'b1;
      state_ff.dOe_b <= 1'b1;
      state_ff.ack <= '1;
      state_ff.byte_ctrl_addr_enable_b <= 1'b1;
      state_ff.word_ctrl_addr_enable_b <= 1'b1;
      state_ff.refOut <= 1'b1;
      state_ff.refOe_b <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign lowPeripheralAddress = state_ff.lowA;
  assign lowAddrOe_b = state_ff.lowOe_b;
  assign midPeripheralAddress = state_ff.midA;
  assign midAddrOe_b = state_ff.midOe_b;
  assign upperHostAddress = state_ff.upA;
  assign upperAddrOe_b = state_ff.upOe_b;
  assign ioWriteStrobe_b = state_ff.iow_b;
  assign ioReadStrobe_b = state_ff.ior_b;
  assign memWriteStrobe_b = state_ff.memw_b;
  assign memReadStrobe_b = state_ff.memr_b;
  assign strobeOe_b = state_ff.strbOe_b;
  assign peripheralDataBus = state_ff.data;
  assign dataOe_b = state_ff.dOe_b;
  assign cpuInterruptOut = state_ff.cpu_interrupt_out;
  assign transferAckLines = state_ff.ack;
  assign busHoldRequest = state_ff.hrq;
  assign byteCtrlAddrEnable_b = state_ff.byte_ctrl_addr_enable_b;
  assign wordCtrlAddrEnable_b = state_ff.word_ctrl_addr_enable_b;
  assign terminalCount = state_ff.tc;
  assign counterTwoOutput = state_ff.counter_two_output;
  assign refreshOut = state_ff.refOut;
  assign refreshOe_b = state_ff.refOe_b;
  assign chipSelects = state_ff.cs;

  AST_OE_ONLY_IN_XFER: assert property (@(posedge clock) disable iff (!rst_b)
    !lowAddrOe_b |-> (state_ff.state inside {APBMC_WAIT, APBMC_STRB, APBMC_DONE}))
    else $error("low address driven outside transfer");
  AST_MID_WITH_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    midAddrOe_b == lowAddrOe_b) else $error("middle address enable mismatch");
  AST_NO_DRIVE_NO_GRANT: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(lowAddrOe_b) |-> $past(busHoldGrant, 2) || $past(busHoldGrant, 3))
    else $error("bus driven without grant");
  AST_MASTER_DISABLES: assert property (@(posedge clock) disable iff (!rst_b || resetIn)
    !masterIn_b |=> state_ff.state == APBMC_IDLE && !busHoldRequest)
    else $error("controller active under external master");
  AST_CPU_INTERRUPT_OUT: assert property (@(posedge clock) disable iff (!rst_b || resetIn)
    (|irqAll) |=> cpuInterruptOut) else $error("interrupt not raised");
  AST_READ_DELAY: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(memReadStrobe_b) |-> $past(state_ff.state, 1) == APBMC_WAIT)
    else $error("read strobe not delayed");
  AST_CS_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    (busHoldGrant && masterIn_b) |=> chipSelects == 7'h00) else $error("decode not gated");
  AST_ACK_DEFAULT: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(rst_b) |-> transferAckLines == 8'hff) else $error("ack not inactive low");
  AST_REFRESH_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    !refreshOe_b |-> state_ff.refreshCyc && !refreshOut) else $error("refresh misdriven");
  COV_XFER: cover property (@(posedge clock) disable iff (!rst_b) $fell(ioReadStrobe_b));
  COV_REFRESH: cover property (@(posedge clock) disable iff (!rst_b) $fell(refreshOe_b));
  COV_TC: cover property (@(posedge clock) disable iff (!rst_b) terminalCount);
endmodule : apbmc_ctrl

/* File: testbench/apbmc_host_model.sv */
`timescale 1ns/1ns
module apbmc_host_model (
  input wire logic clock,
  input wire logic busHoldRequest,
  input wire logic strobeOe_b,
  input wire logic [7:0] grantDelay,
  input wire logic [7:0] stallCycles,
  output logic busHoldGrant,
  output logic channelReadyIn
);
  logic [7:0] waitCnt = 8'h00;
  logic [7:0] stallCnt = 8'h00;
  initial begin
    busHoldGrant = 1'b0;
    channelReadyIn = 1'b1;
  end
  // grant after the host has let go of the bus, withdraw once hold drops
  always @(posedge clock) begin
    if (busHoldRequest !== 1'b1) begin
      busHoldGrant <= 1'b0;
      waitCnt <= 8'h00;
    end else if (waitCnt >= grantDelay) begin
      busHoldGrant <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 8'h01;
    end
  end
  // slow adapter keeps ready low for a while once strobes start
  always @(posedge clock) begin
    if (strobeOe_b !== 1'b0) begin
      stallCnt <= 8'h00;
      channelReadyIn <= 1'b1;
    end else if (stallCnt < stallCycles) begin
      stallCnt <= stallCnt + 8'h01;
      channelReadyIn <= 1'b0;
    end else begin
      channelReadyIn <= 1'b1;
    end
  end
endmodule : apbmc_host_model

/* File: testbench/apbmc_ctrl_tb.sv */
`timescale 1ns/1ns
module apbmc_ctrl_tb;
  import apbmc_pkg::*;
  localparam int XCNT = 2;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic resetIn = 1'b0;
  logic [NUM_CHAN-1:0] transferRequestLines = '0;
  logic [NUM_IRQ-1:0] interruptRequestLines = '0;
  logic interruptAckIn = 1'b1;
  logic masterIn_b = 1'b1;
  logic timerClockIn = 1'b0;
  logic [LOW_AW-1:0] lowAddrIn = '0;
  logic [7:0] dataIn = 8'h00;
  logic ackActiveHigh = 1'b0;
  logic memWriteDrive_b = 1'b1;
  logic ioWriteDrive_b = 1'b1;
  logic [23:0] expAddr = BASE_ADDR_RESET;
  logic [7:0] grantDelay = 8'h02;
  logic [7:0] stallCycles = 8'h00;
  logic busHoldGrant, channelReadyIn, ioWriteStrobeIn_b, memWriteStrobeIn_b, refreshIn_b;
  logic [LOW_AW-1:0] lowPeripheralAddress;
  logic [MID_AW-1:0] midPeripheralAddress;
  logic [UP_AW-1:0] upperHostAddress;
  logic [7:0] peripheralDataBus, transferAckLines;
  logic [6:0] chipSelects;
  logic lowAddrOe_b, midAddrOe_b, upperAddrOe_b, ioWriteStrobe_b, ioReadStrobe_b, strobeOe_b;
  logic memWriteStrobe_b, memReadStrobe_b, dataOe_b, cpuInterruptOut, busHoldRequest;
  logic byteCtrlAddrEnable_b, wordCtrlAddrEnable_b, terminalCount, counterTwoOutput;
  logic refreshOut, refreshOe_b;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h9d58;
  logic [31:0] tcSeen = '0;
  // two-way strobes and open-drain refresh with pull-up
  assign ioWriteStrobeIn_b = strobeOe_b ? ioWriteDrive_b : ioWriteStrobe_b;
  assign memWriteStrobeIn_b = strobeOe_b ? memWriteDrive_b : memWriteStrobe_b;
  assign refreshIn_b = refreshOe_b ? 1'b1 : refreshOut;
  apbmc_ctrl #(.XFER_COUNT(XCNT)) dut_u (.clock, .rst_b, .resetIn, .transferRequestLines,
    .interruptRequestLines, .interruptAckIn, .busHoldGrant, .masterIn_b, .channelReadyIn,
    .timerClockIn, .lowAddrIn, .ioWriteStrobeIn_b, .memWriteStrobeIn_b, .refreshIn_b, .dataIn,
    .ackActiveHigh, .lowPeripheralAddress, .lowAddrOe_b, .midPeripheralAddress, .midAddrOe_b,
    .upperHostAddress, .upperAddrOe_b, .ioWriteStrobe_b, .ioReadStrobe_b, .memWriteStrobe_b,
    .memReadStrobe_b, .strobeOe_b, .peripheralDataBus, .dataOe_b, .cpuInterruptOut,
    .transferAckLines, .busHoldRequest, .byteCtrlAddrEnable_b, .wordCtrlAddrEnable_b,
    .terminalCount, .counterTwoOutput, .refreshOut, .refreshOe_b, .chipSelects);
  apbmc_host_model host_u (.clock, .busHoldRequest, .strobeOe_b, .grantDelay, .stallCycles,
    .busHoldGrant, .channelReadyIn);
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (terminalCount === 1'b1) tcSeen <= tcSeen + 32'h1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [6:0] expCs(input logic [LOW_AW-1:0] a);
    case (a[LOW_AW-1:SEL_LSB])
      SEL_PORT_GATE: return (a[4] == 1'b0 && a[0] == 1'b1) ? 7'h40 : 7'h00;
      SEL_BYTE_CTRL: return 7'h01;
      SEL_INT_LO: return 7'h02;
      SEL_TIMER: return 7'h04;
      SEL_PAGE: return 7'h08;
      SEL_INT_HI: return 7'h10;
      SEL_WORD_CTRL: return 7'h20;
      default: return 7'h00;
    endcase
  endfunction : expCs
  function automatic logic [7:0] expVec(input logic [15:0] q);
    for (int k = 0; k < 16; k++) begin
      if (q[k]) return k[7:0];
    end
    return 8'h00;
  endfunction : expVec
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic xfer(input int ch, input logic hi, input logic [7:0] stall, output int len);
    int i;
    ackActiveHigh = hi;
    stallCycles = stall;
    tick(1);
    check("idle ack", transferAckLines, hi ? 8'h00 : 8'hff);
    transferRequestLines[ch] = 1'b1;
    for (i = 0; i < 40 && busHoldRequest !== 1'b1; i++) tick(1);
    check("hold request", busHoldRequest, 1'b1);
    check("oe before grant", {busHoldGrant, lowAddrOe_b}, 2'b01);
    for (i = 0; i < 60 && lowAddrOe_b !== 1'b0; i++) tick(1);
    check("drive", {busHoldGrant, midAddrOe_b, upperAddrOe_b, strobeOe_b}, 4'h8);
    check("ack", transferAckLines, 8'(hi ? 8'h01 << ch : ~(8'h01 << ch)));
    check("aen", {wordCtrlAddrEnable_b, byteCtrlAddrEnable_b}, ch < 4 ? 2'b10 : 2'b01);
    check("address", {upperHostAddress, midPeripheralAddress, lowPeripheralAddress},
      expAddr);
    expAddr = expAddr + 24'h000001;
    check("read lead", memReadStrobe_b, 1'b1);
    check("selects off", chipSelects, 7'h00);
    transferRequestLines[ch] = 1'b0;
    len = 0;
    for (i = 0; i < 200 && lowAddrOe_b !== 1'b1; i++) begin
      tick(1);
      if (memReadStrobe_b === 1'b0) len++;
    end
    check("release", {lowAddrOe_b, midAddrOe_b, strobeOe_b}, 3'b111);
    for (i = 0; i < 40 && busHoldRequest !== 1'b0; i++) tick(1);
  endtask : xfer
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    results();
  end
  initial begin
    int i;
    int ch;
    int len;
    logic [31:0] base;
    logic [4:0] sel;
    tick(8);
    rst_b = 1'b1;
    tick(1);
    check("reset state", {busHoldRequest, lowAddrOe_b, midAddrOe_b, upperAddrOe_b, strobeOe_b,
      dataOe_b, byteCtrlAddrEnable_b, wordCtrlAddrEnable_b}, 8'h7f);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      sel = (i == 7) ? 5'h07 : seed[9:5];
      lowAddrIn = {sel, seed[4:0]};
      tick(2);
      check("select", chipSelects, expCs(lowAddrIn));
    end
    base = tcSeen;
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      ch = (seed[2:0] == 3'd4) ? 5 : int'(seed[2:0]);
      grantDelay = {5'h00, seed[5:3]};
      xfer(ch, seed[6], 8'h00, len);
    end
    tick(4);
    check("terminal count", tcSeen - base, 6 / XCNT);
    xfer(1, 1'b0, 8'd20, len);
    check("stretch", len > 12, 1'b1);
    transferRequestLines[CASCADE_CHAN] = 1'b1;
    tick(40);
    check("cascade channel", busHoldRequest, 1'b0);
    transferRequestLines = '0;
    masterIn_b = 1'b0;
    transferRequestLines[2] = 1'b1;
    tick(40);
    check("master", {busHoldRequest, upperAddrOe_b}, 2'b01);
    transferRequestLines = '0;
    masterIn_b = 1'b1;
    tick(10);
    transferRequestLines[6] = 1'b1;
    for (i = 0; i < 40 && busHoldRequest !== 1'b1; i++) tick(1);
    resetIn = 1'b1;
    tick(1);
    resetIn = 1'b0;
    transferRequestLines = '0;
    expAddr = BASE_ADDR_RESET;
    check("mid reset", {busHoldRequest, lowAddrOe_b, strobeOe_b}, 3'b011);
    tick(10);
    lowAddrIn = 10'h061;
    dataIn = 8'h01;
    ioWriteDrive_b = 1'b0;
    tick(1);
    ioWriteDrive_b = 1'b1;
    check("port select", chipSelects, expCs(lowAddrIn));
    interruptRequestLines = 16'h0005;
    tick(10);
    check("internal irq", cpuInterruptOut, 1'b0);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      interruptRequestLines = (seed[15:0] | 16'h8000) & 16'hfffa;
      tick(10);
      check("interrupt", cpuInterruptOut, 1'b1);
      interruptAckIn = 1'b0;
      tick(2);
      check("vector", {dataOe_b, peripheralDataBus},
        {1'b0, expVec(interruptRequestLines)});
      interruptAckIn = 1'b1;
      interruptRequestLines = '0;
      tick(4);
    end
    transferRequestLines[0] = 1'b1;
    tick(20);
    check("arbiter off", busHoldRequest, 1'b0);
    memWriteDrive_b = 1'b0;
    tick(1);
    memWriteDrive_b = 1'b1;
    xfer(0, 1'b0, 8'h00, len);
    for (i = 0; i < 3000 && !(busHoldGrant === 1'b1 && refreshIn_b === 1'b0); i++) begin
      tick(1);
      if (i % 8 == 0) timerClockIn = ~timerClockIn;
    end
    check("refresh", {refreshIn_b, upperAddrOe_b}, 2'b00);
    check("counter two", counterTwoOutput, 1'b1);
    results();
  end
endmodule : apbmc_ctrl_tb
